// *** hw/rss_top.sv ***
// supervisory and status logic of a serial real-time clock, with an AXI4-Lite register port
// assumes sys_rst_i marks the first application of power; supply and battery levels are pins
//
// Operation
// - supply-fail output low while sense below threshold
// - in backup, comparator off, fail output held low
// - on return, fail high for recovery time
// - century flag toggles at rollover only if allowed
// - shared pin follows general output bit when idle
// - shared pin driven only as open-drain low
// - battery tested at power-up and daily
// - battery-low flag holds until a passing test
// - battery tests only while main supply present
// - recovery-length select bit in register 04h
// - recovery time chosen by select and halt bits
// - writes refused during recovery deselect interval
// - first power-up loads full set of defaults
// - later power-up clears enables, sets freeze bit
module rss_top
   import rss_pkg::*;
#(
   parameter int unsigned REC_SLOW_CYC = rss_pkg::REC_SLOW_CYC,
   parameter int unsigned REC_HALT_CYC = rss_pkg::REC_HALT_CYC,
   parameter int unsigned REC_FAST_CYC = rss_pkg::REC_FAST_CYC,
   parameter int unsigned MS_TICK_CYC = rss_pkg::MS_TICK_CYC,
   parameter int unsigned CHECK_MS = rss_pkg::CHECK_MS
) (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic [rss_pkg::ADDR_W-1:0] s_axi_awaddr_i,
   input wire logic [2:0] s_axi_awprot_i,
   input wire logic s_axi_awvalid_i,
   output logic s_axi_awready_o,
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0] s_axi_wstrb_i,
   input wire logic s_axi_wvalid_i,
   output logic s_axi_wready_o,
   output logic [1:0] s_axi_bresp_o,
   output logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   input wire logic [rss_pkg::ADDR_W-1:0] s_axi_araddr_i,
   input wire logic [2:0] s_axi_arprot_i,
   input wire logic s_axi_arvalid_i,
   output logic s_axi_arready_o,
   output logic [31:0] s_axi_rdata_o,
   output logic [1:0] s_axi_rresp_o,
   output logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   input wire logic supply_sense_i,
   input wire logic vcc_ok_i,
   input wire logic battery_ok_i,
   input wire logic century_rollover_i,
   input wire logic func_pin_low_i,
   input wire logic shared_irq_pin_i,
   output logic supply_fail_out_o,
   output logic shared_irq_pin_o,
   output logic shared_irq_pin_oe_o,
   output logic irq_o,
   output logic oscillator_halt_o,
   output logic update_freeze_o,
   output logic century_flag_o,
   output logic frequency_test_o,
   output logic alarm_irq_allow_o,
   output logic backup_alarm_allow_o,
   output logic square_wave_on_o,
   output logic [7:0] watchdog_o
);
   import rss_pkg::*;

   // ----------------------------------------
   // pin synchronisers and timebase
   // ----------------------------------------
   logic sense_s;
   logic vcc_ok_s;
   logic bat_ok_s;
   logic pin_s;
   logic ms_tick;
   logic day_tick;
   rss_sup_state_t state_reg;

   // comparator result enters the clock domain only through two flops
   rss_sync #(.W(4)) u_sync (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .async_i({supply_sense_i, vcc_ok_i, battery_ok_i, shared_irq_pin_i}),
      .sync_o({sense_s, vcc_ok_s, bat_ok_s, pin_s})
   );

   rss_tick #(.W(MS_W), .N(MS_TICK_CYC)) u_ms (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .en_i(1'b1),
      .clr_i(1'b0),
      .tick_o(ms_tick)
   );

   // the daily schedule restarts whenever main supply is lost
   rss_tick #(.W(CHECK_W), .N(CHECK_MS)) u_day (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .en_i(ms_tick && state_reg == S_RUN),
      .clr_i(!vcc_ok_s),
      .tick_o(day_tick)
   );

   // ----------------------------------------
   // control registers
   // ----------------------------------------
   logic century_allow_reg;
   logic century_flag_reg;
   logic rec_sel_reg;
   logic gen_out_bit_reg;
   logic freq_test_reg;
   logic [7:0] wdog_reg;
   logic alarm_allow_reg;
   logic sqw_on_reg;
   logic backup_alarm_reg;
   logic halt_reg;
   logic freeze_reg;
   logic bat_low_reg;
   logic [EVT_W-1:0] irq_stat_reg;
   logic [EVT_W-1:0] irq_mask_reg;
   logic [EVT_W-1:0] evt;

   // ----------------------------------------
   // write channel
   // ----------------------------------------
   logic aw_hold_reg;
   logic [5:0] aw_idx_reg;
   logic w_hold_reg;
   logic [7:0] w_data_reg;
   logic w_lane_reg;
   logic wr_go;
   logic wr_en;
   logic [7:0] wd;

   function automatic logic is_mapped(input logic [5:0] idx);
      return idx == IDX_HALT || idx == IDX_CENTURY || idx == IDX_REC || idx == IDX_CTRL ||
             idx == IDX_WDOG || idx == IDX_ALARM || idx == IDX_FREEZE || idx == IDX_FLAGS ||
             idx == IDX_IRQ_STAT || idx == IDX_IRQ_MASK || idx == IDX_SUP_STAT;
   endfunction

   assign s_axi_awready_o = !aw_hold_reg && !s_axi_bvalid_o;
   assign s_axi_wready_o = !w_hold_reg && !s_axi_bvalid_o;
   assign wr_go = aw_hold_reg && w_hold_reg && !s_axi_bvalid_o;
   // deselected while supply is away or recovering: the write is answered but not stored
   assign wr_en = wr_go && w_lane_reg && is_mapped(aw_idx_reg) && state_reg == S_RUN;
   assign wd = w_data_reg;

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         aw_hold_reg <= 1'b0;
         aw_idx_reg <= '0;
         w_hold_reg <= 1'b0;
         w_data_reg <= '0;
         w_lane_reg <= 1'b0;
      end else begin
         if (s_axi_awvalid_i && s_axi_awready_o) begin
            aw_hold_reg <= 1'b1;
            aw_idx_reg <= s_axi_awaddr_i[7:2];
         end else if (wr_go) begin
            aw_hold_reg <= 1'b0;
         end
         if (s_axi_wvalid_i && s_axi_wready_o) begin
            w_hold_reg <= 1'b1;
            w_data_reg <= s_axi_wdata_i[7:0];
            w_lane_reg <= s_axi_wstrb_i[0];
         end else if (wr_go) begin
            w_hold_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         s_axi_bvalid_o <= 1'b0;
         s_axi_bresp_o <= RESP_OKAY;
      end else if (wr_go) begin
         s_axi_bvalid_o <= 1'b1;
         if (!is_mapped(aw_idx_reg)) begin
            s_axi_bresp_o <= RESP_DECERR;
         end else if (state_reg != S_RUN) begin
            s_axi_bresp_o <= RESP_SLVERR;
         end else begin
            s_axi_bresp_o <= RESP_OKAY;
         end
      end else if (s_axi_bready_i) begin
         s_axi_bvalid_o <= 1'b0;
      end
   end

   // ----------------------------------------
   // supply state and recovery timer
   // ----------------------------------------
   logic [REC_W-1:0] rec_cnt_reg;
   logic [REC_W-1:0] rec_len;
   logic power_up;

   always_comb begin
      if (rec_sel_reg) begin
         rec_len = REC_W'(REC_FAST_CYC);
      end else if (halt_reg) begin
         rec_len = REC_W'(REC_HALT_CYC);
      end else begin
         rec_len = REC_W'(REC_SLOW_CYC);
      end
   end

   assign power_up = state_reg == S_BACKUP && vcc_ok_s;

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         state_reg <= S_BACKUP;
         rec_cnt_reg <= '0;
      end else begin
         unique case (state_reg)
            S_BACKUP: begin
               if (vcc_ok_s) begin
                  state_reg <= S_RECOVER;
                  rec_cnt_reg <= rec_len;
               end
            end
            S_RECOVER: begin
               if (!vcc_ok_s) begin
                  state_reg <= S_BACKUP;
               end else if (rec_cnt_reg <= REC_W'(1)) begin
                  state_reg <= S_RUN;
               end else begin
                  rec_cnt_reg <= rec_cnt_reg - 1'b1;
               end
            end
            S_RUN: begin
               if (!vcc_ok_s) begin
                  state_reg <= S_BACKUP;
               end
            end
            default: begin
               state_reg <= S_BACKUP;
            end
         endcase
      end
   end

   // held low from reset: no supply is assumed good until recovery begins
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         supply_fail_out_o <= 1'b0;
      end else if (state_reg == S_BACKUP || !vcc_ok_s) begin
         supply_fail_out_o <= 1'b0;
      end else if (state_reg == S_RECOVER) begin
         supply_fail_out_o <= 1'b1;
      end else begin
         supply_fail_out_o <= sense_s;
      end
   end

   // ----------------------------------------
   // control bits and power-up defaults
   // ----------------------------------------
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rec_sel_reg <= 1'b0;
         halt_reg <= 1'b1;
         gen_out_bit_reg <= 1'b1;
      end else if (wr_en) begin
         if (aw_idx_reg == IDX_REC) begin
            rec_sel_reg <= wd[B_REC_SEL];
         end
         if (aw_idx_reg == IDX_HALT) begin
            halt_reg <= wd[B_HALT];
         end
         if (aw_idx_reg == IDX_CTRL) begin
            gen_out_bit_reg <= wd[B_GEN_OUT];
         end
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         freq_test_reg <= 1'b0;
         wdog_reg <= WDOG_RST;
         alarm_allow_reg <= 1'b0;
         sqw_on_reg <= 1'b0;
         backup_alarm_reg <= 1'b0;
         freeze_reg <= 1'b1;
      end else if (power_up) begin
         freq_test_reg <= 1'b0;
         wdog_reg <= WDOG_RST;
         alarm_allow_reg <= 1'b0;
         sqw_on_reg <= 1'b0;
         backup_alarm_reg <= 1'b0;
         freeze_reg <= 1'b1;
      end else if (wr_en) begin
         if (aw_idx_reg == IDX_CTRL) begin
            freq_test_reg <= wd[B_FREQ_TEST];
         end
         if (aw_idx_reg == IDX_WDOG) begin
            wdog_reg <= wd;
         end
         if (aw_idx_reg == IDX_ALARM) begin
            alarm_allow_reg <= wd[B_ALARM_IRQ];
            sqw_on_reg <= wd[B_SQW_ON];
            backup_alarm_reg <= wd[B_BACKUP_ALARM];
         end
         if (aw_idx_reg == IDX_FREEZE) begin
            freeze_reg <= wd[B_FREEZE];
         end
      end
   end

   // a rollover in the cycle of a write toggles the freshly written flag if the written allow bit is set
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         century_allow_reg <= 1'b0;
         century_flag_reg <= 1'b0;
      end else begin
         if (wr_en && aw_idx_reg == IDX_CENTURY) begin
            century_allow_reg <= wd[B_CENT_ALLOW];
            century_flag_reg <= wd[B_CENT_FLAG] ^ (century_rollover_i && wd[B_CENT_ALLOW]);
         end else if (century_rollover_i && century_allow_reg) begin
            century_flag_reg <= !century_flag_reg;
         end
      end
   end

   // ----------------------------------------
   // battery monitor
   // ----------------------------------------
   logic bat_test;

   assign bat_test = power_up || day_tick;

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         bat_low_reg <= 1'b0;
      end else if (bat_test) begin
         bat_low_reg <= !bat_ok_s;
      end
   end

   // ----------------------------------------
   // shared pin and interrupt
   // ----------------------------------------
   logic pin_is_gen_out;

   // with the alarm, test and watchdog functions idle the pin is a plain output
   assign pin_is_gen_out = !freq_test_reg && !alarm_allow_reg && wdog_reg == WDOG_RST;
   assign shared_irq_pin_o = 1'b0;

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         shared_irq_pin_oe_o <= 1'b0;
      end else if (pin_is_gen_out) begin
         shared_irq_pin_oe_o <= !gen_out_bit_reg;
      end else begin
         shared_irq_pin_oe_o <= func_pin_low_i;
      end
   end

   assign evt[EV_BAT_LOW] = bat_test && !bat_ok_s;
   assign evt[EV_SUP_FAIL] = state_reg == S_RUN && (!sense_s || !vcc_ok_s) && supply_fail_out_o;
   assign evt[EV_CENTURY] = century_rollover_i && century_allow_reg;
   assign evt[EV_REC_DONE] = state_reg == S_RECOVER && vcc_ok_s && rec_cnt_reg <= REC_W'(1);

   // set wins over a clearing write in the same cycle
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         irq_stat_reg <= '0;
         irq_mask_reg <= '0;
      end else begin
         if (wr_en && aw_idx_reg == IDX_IRQ_STAT) begin
            irq_stat_reg <= (irq_stat_reg & ~wd[EVT_W-1:0]) | evt;
         end else begin
            irq_stat_reg <= irq_stat_reg | evt;
         end
         if (wr_en && aw_idx_reg == IDX_IRQ_MASK) begin
            irq_mask_reg <= wd[EVT_W-1:0];
         end
      end
   end

   assign irq_o = |(irq_stat_reg & irq_mask_reg);

   // ----------------------------------------
   // read channel
   // ----------------------------------------
   logic [7:0] rd_byte;
   logic [5:0] rd_idx;

   assign rd_idx = s_axi_araddr_i[7:2];
   assign s_axi_arready_o = !s_axi_rvalid_o;

   always_comb begin
      rd_byte = '0;
      unique case (rd_idx)
         IDX_HALT: rd_byte[B_HALT] = halt_reg;
         IDX_CENTURY: rd_byte = {century_allow_reg, century_flag_reg, 6'h00};
         IDX_REC: rd_byte[B_REC_SEL] = rec_sel_reg;
         IDX_CTRL: rd_byte = {gen_out_bit_reg, freq_test_reg, 6'h00};
         IDX_WDOG: rd_byte = wdog_reg;
         IDX_ALARM: rd_byte = {alarm_allow_reg, sqw_on_reg, backup_alarm_reg, 5'h00};
         IDX_FREEZE: rd_byte[B_FREEZE] = freeze_reg;
         IDX_FLAGS: rd_byte[B_BAT_LOW] = bat_low_reg;
         IDX_IRQ_STAT: rd_byte[EVT_W-1:0] = irq_stat_reg;
         IDX_IRQ_MASK: rd_byte[EVT_W-1:0] = irq_mask_reg;
         IDX_SUP_STAT: rd_byte = {2'h0, pin_s, bat_ok_s, sense_s, supply_fail_out_o, state_reg};
         default: rd_byte = '0;
      endcase
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         s_axi_rvalid_o <= 1'b0;
         s_axi_rdata_o <= '0;
         s_axi_rresp_o <= RESP_OKAY;
      end else if (s_axi_arvalid_i && s_axi_arready_o) begin
         s_axi_rvalid_o <= 1'b1;
         s_axi_rdata_o <= {24'h000000, rd_byte};
         s_axi_rresp_o <= is_mapped(rd_idx) ? RESP_OKAY : RESP_DECERR;
      end else if (s_axi_rready_i) begin
         s_axi_rvalid_o <= 1'b0;
      end
   end

   // ----------------------------------------
   // control bits seen by neighbouring blocks
   // ----------------------------------------
   assign oscillator_halt_o = halt_reg;
   assign update_freeze_o = freeze_reg;
   assign century_flag_o = century_flag_reg;
   assign frequency_test_o = freq_test_reg;
   assign alarm_irq_allow_o = alarm_allow_reg;
   assign backup_alarm_allow_o = backup_alarm_reg;
   assign square_wave_on_o = sqw_on_reg;
   assign watchdog_o = wdog_reg;
endmodule

// *** hw/rss_pkg.sv ***
// constants shared by the supervisory and status logic of the serial clock
// assumes a 25 MHz core clock and an AXI4-Lite register port with 8-bit registers in word slots
package rss_pkg;
   // ----------------------------------------
   // clock and timing
   // ----------------------------------------
   localparam int unsigned CLK_KHZ = 25000;
   localparam int unsigned CLK_MHZ = 25;
   localparam int unsigned REC_SLOW_MS = 96;
   localparam int unsigned REC_HALT_MS = 40;
   localparam int unsigned REC_FAST_US = 50;
   localparam int unsigned REC_SLOW_CYC = REC_SLOW_MS * CLK_KHZ;
   localparam int unsigned REC_HALT_CYC = REC_HALT_MS * CLK_KHZ;
   localparam int unsigned REC_FAST_CYC = REC_FAST_US * CLK_MHZ;
   localparam int unsigned REC_W = 22;
   localparam int unsigned MS_TICK_CYC = CLK_KHZ;
   localparam int unsigned MS_W = 15;
   localparam int unsigned CHECK_HOURS = 24;
   localparam int unsigned CHECK_MS = CHECK_HOURS * 3600 * 1000;
   localparam int unsigned CHECK_W = 27;

   // ----------------------------------------
   // register indices (byte address = 4 * index)
   // ----------------------------------------
   localparam int unsigned ADDR_W = 8;
   localparam logic [5:0] IDX_HALT = 6'h01;
   localparam logic [5:0] IDX_CENTURY = 6'h03;
   localparam logic [5:0] IDX_REC = 6'h04;
   localparam logic [5:0] IDX_CTRL = 6'h08;
   localparam logic [5:0] IDX_WDOG = 6'h09;
   localparam logic [5:0] IDX_ALARM = 6'h0a;
   localparam logic [5:0] IDX_FREEZE = 6'h0c;
   localparam logic [5:0] IDX_FLAGS = 6'h0f;
   localparam logic [5:0] IDX_IRQ_STAT = 6'h10;
   localparam logic [5:0] IDX_IRQ_MASK = 6'h11;
   localparam logic [5:0] IDX_SUP_STAT = 6'h12;

   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int unsigned B_HALT = 7;
   localparam int unsigned B_CENT_ALLOW = 7;
   localparam int unsigned B_CENT_FLAG = 6;
   localparam int unsigned B_REC_SEL = 7;
   localparam int unsigned B_GEN_OUT = 7;
   localparam int unsigned B_FREQ_TEST = 6;
   localparam int unsigned B_ALARM_IRQ = 7;
   localparam int unsigned B_SQW_ON = 6;
   localparam int unsigned B_BACKUP_ALARM = 5;
   localparam int unsigned B_FREEZE = 6;
   localparam int unsigned B_BAT_LOW = 4;

   // ----------------------------------------
   // interrupt events
   // ----------------------------------------
   localparam int unsigned EVT_W = 4;
   localparam int unsigned EV_BAT_LOW = 0;
   localparam int unsigned EV_SUP_FAIL = 1;
   localparam int unsigned EV_CENTURY = 2;
   localparam int unsigned EV_REC_DONE = 3;

   // ----------------------------------------
   // bus answers and reset values
   // ----------------------------------------
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [1:0] RESP_DECERR = 2'h3;
   localparam logic [7:0] WDOG_RST = 8'h00;

   typedef enum logic [1:0] {
      S_BACKUP = 2'b00,
      S_RECOVER = 2'b01,
      S_RUN = 2'b11
   } rss_sup_state_t;
endpackage

// *** hw/rss_sync.sv ***
// two-flop synchroniser for a bundle of independent levels
// assumes each bit is a slow level from a pin; bits are not coherent with one another
module rss_sync #(
   parameter int unsigned W = 1
) (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic [W-1:0] async_i,
   output logic [W-1:0] sync_o
);
   logic [W-1:0] meta_reg;

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         meta_reg <= '0;
         sync_o <= '0;
      end else begin
         meta_reg <= async_i;
         sync_o <= meta_reg;
      end
   end
endmodule

// *** hw/rss_tick.sv ***
// free counter that emits a one-cycle enable every N counted cycles
// assumes en_i and clr_i come from the same clock domain
module rss_tick #(
   parameter int unsigned W = 16,
   parameter int unsigned N = 1000
) (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic en_i,
   input wire logic clr_i,
   output logic tick_o
);
   localparam logic [W-1:0] LAST = W'(N - 1);
   logic [W-1:0] cnt_reg;

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         cnt_reg <= '0;
         tick_o <= 1'b0;
      end else begin
         tick_o <= 1'b0;
         if (clr_i) begin
            cnt_reg <= '0;
         end else if (en_i) begin
            if (cnt_reg == LAST) begin
               cnt_reg <= '0;
               tick_o <= 1'b1;
            end else begin
               cnt_reg <= cnt_reg + 1'b1;
            end
         end
      end
   end
endmodule

// *** test/rss_supply_model.sv ***
// supply divider, battery and pulled-up shared pin around the block
// assumes commands from the bench change just after a rising clock edge
module rss_supply_model (
   input wire logic clk_i,
   input wire logic supply_on_i,
   input wire logic sense_lvl_i,
   input wire logic bat_lvl_i,
   input wire logic pin_oe_i,
   output logic vcc_ok_o,
   output logic sense_o,
   output logic bat_ok_o,
   output logic pin_o
);
   timeunit 1ns;
   timeprecision 1ns;
   always_ff @(posedge clk_i) vcc_ok_o <= supply_on_i;
   // the divider sags with the supply, so sense is low whenever vcc is gone
   assign sense_o = vcc_ok_o & sense_lvl_i;
   assign bat_ok_o = bat_lvl_i;
   assign pin_o = pin_oe_i ? 1'b0 : 1'b1;
endmodule

// *** test/rss_top_sva.sv ***
// assertions on the supervisory block, seen through its top ports
// assumes one clock domain and the asynchronous reset sys_rst_i
module rss_top_sva (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic vcc_ok_i,
   input wire logic supply_sense_i,
   input wire logic century_rollover_i,
   input wire logic func_pin_low_i,
   input wire logic s_axi_bready_i,
   input wire logic s_axi_rready_i,
   input wire logic s_axi_bvalid_o,
   input wire logic [1:0] s_axi_bresp_o,
   input wire logic s_axi_rvalid_o,
   input wire logic [31:0] s_axi_rdata_o,
   input wire logic supply_fail_out_o,
   input wire logic shared_irq_pin_o,
   input wire logic shared_irq_pin_oe_o,
   input wire logic century_flag_o,
   input wire logic frequency_test_o,
   input wire logic alarm_irq_allow_o,
   input wire logic [7:0] watchdog_o
);
   logic mode_on;
   assign mode_on = frequency_test_o | alarm_irq_allow_o | (|watchdog_o);
   default clocking @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   a_pin_only_low: assert property (shared_irq_pin_o == 1'b0)
      else $error("shared pin driven high");
   a_fail_in_backup: assert property (!vcc_ok_i [*4] |-> !supply_fail_out_o)
      else $error("fail output high without supply");
   a_fail_low_cause: assert property ($fell(supply_fail_out_o) |-> !$past(supply_sense_i, 3) || !$past(vcc_ok_i, 3))
      else $error("fail output fell without cause");
   a_recover_high: assert property ($rose(vcc_ok_i) |-> ##[3:6] supply_fail_out_o)
      else $error("fail output not forced high");
   a_century_cause: assert property ($changed(century_flag_o) |-> $past(century_rollover_i) || $rose(s_axi_bvalid_o))
      else $error("century flag changed alone");
   a_pin_func_mode: assert property (mode_on |=> shared_irq_pin_oe_o == $past(func_pin_low_i))
      else $error("shared pin ignores function");
   a_bresp_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
      else $error("write answer dropped");
   a_rdata_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
      else $error("read answer dropped");
endmodule
bind rss_top rss_top_sva u_sva (.*);

// *** test/rss_top_bench.sv ***
// self-checking bench: bus master tasks, supply model and comparisons
// assumes the checker binds itself to rss_top
module rss_top_bench;
   import rss_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int RF = 5, RH = 20, RS = 40;
   logic clk_i = 0, sys_rst_i = 1, s_axi_awvalid_i = 0, s_axi_wvalid_i = 0, s_axi_bready_i = 0;
   logic s_axi_arvalid_i = 0, s_axi_rready_i = 0, century_rollover_i = 0, func_pin_low_i = 0;
   logic [7:0] s_axi_awaddr_i = 0, s_axi_araddr_i = 0, watchdog_o;
   logic [2:0] s_axi_awprot_i = 3'h0, s_axi_arprot_i = 3'h0;
   logic [31:0] s_axi_wdata_i = 0, s_axi_rdata_o, rdat;
   logic [3:0] s_axi_wstrb_i = 4'hf;
   logic [1:0] s_axi_bresp_o, s_axi_rresp_o, resp;
   logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o, irq_o;
   logic supply_fail_out_o, shared_irq_pin_o, shared_irq_pin_oe_o, oscillator_halt_o, update_freeze_o;
   logic century_flag_o, frequency_test_o, alarm_irq_allow_o, backup_alarm_allow_o, square_wave_on_o;
   logic supply_sense_i, vcc_ok_i, battery_ok_i, shared_irq_pin_i;
   logic supply_on = 0, sense_lvl = 0, bat_lvl = 1;
   int miscompares = 0, cmp_count = 0, seed = 96, v;
   always #20 clk_i = ~clk_i;
   rss_top #(.REC_SLOW_CYC(RS), .REC_HALT_CYC(RH), .REC_FAST_CYC(RF), .MS_TICK_CYC(20), .CHECK_MS(3)) uut (.*);
   rss_supply_model u_model (.clk_i(clk_i), .supply_on_i(supply_on), .sense_lvl_i(sense_lvl), .bat_lvl_i(bat_lvl),
      .pin_oe_i(shared_irq_pin_oe_o), .vcc_ok_o(vcc_ok_i), .sense_o(supply_sense_i), .bat_ok_o(battery_ok_i),
      .pin_o(shared_irq_pin_i));
   // ----
   // tasks
   // ----
   function automatic int rec_exp(logic sel, logic halt);
      return sel ? RF : (halt ? RH : RS);
   endfunction
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      cmp_count++;
      if (s !== e) begin
         miscompares++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic stop_test;
      $display("compares=%0d mismatches=%0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic wr(input logic [5:0] i, input logic [7:0] d);
      logic aw_go, w_go;
      @(posedge clk_i);
      s_axi_awaddr_i <= {i, 2'b00};
      s_axi_wdata_i <= {24'h0, d};
      s_axi_awvalid_i <= 1'b1;
      s_axi_wvalid_i <= 1'b1;
      // each channel is let go at its own handshake edge
      do begin
         @(negedge clk_i);
         aw_go = s_axi_awvalid_i && s_axi_awready_o;
         w_go = s_axi_wvalid_i && s_axi_wready_o;
         @(posedge clk_i);
         if (aw_go) s_axi_awvalid_i <= 1'b0;
         if (w_go) s_axi_wvalid_i <= 1'b0;
      end while (s_axi_awvalid_i && !aw_go || s_axi_wvalid_i && !w_go);
      do @(negedge clk_i); while (!s_axi_bvalid_o);
      // bready comes a cycle late so the answer has to wait for it
      @(posedge clk_i) s_axi_bready_i <= 1'b1;
      @(negedge clk_i) resp = s_axi_bresp_o;
      @(posedge clk_i) s_axi_bready_i <= 1'b0;
   endtask
   task automatic rd(input logic [5:0] i);
      @(posedge clk_i);
      s_axi_araddr_i <= {i, 2'b00};
      s_axi_arvalid_i <= 1'b1;
      do @(negedge clk_i); while (!s_axi_arready_o);
      @(posedge clk_i) s_axi_arvalid_i <= 1'b0;
      do @(negedge clk_i); while (!s_axi_rvalid_o);
      @(posedge clk_i) s_axi_rready_i <= 1'b1;
      @(negedge clk_i) begin
         rdat = s_axi_rdata_o;
         resp = s_axi_rresp_o;
      end
      @(posedge clk_i) s_axi_rready_i <= 1'b0;
   endtask
   task automatic roll;
      @(posedge clk_i) century_rollover_i <= 1'b1;
      @(posedge clk_i) century_rollover_i <= 1'b0;
   endtask
   task automatic pwr(input int rec);
      int n;
      n = 0;
      sense_lvl <= 1'b0;
      supply_on <= 1'b0;
      repeat (8) @(posedge clk_i);
      supply_on <= 1'b1;
      do begin
         @(negedge clk_i);
         n += supply_fail_out_o;
      end while (n == 0 || supply_fail_out_o);
      chk(n >= rec && n <= rec + 2, 1);
   endtask
   // ----
   // main sequence
   // ----
   initial begin
      repeat (2) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      @(negedge clk_i);
      chk({oscillator_halt_o, update_freeze_o, frequency_test_o, alarm_irq_allow_o, backup_alarm_allow_o,
         square_wave_on_o, watchdog_o, shared_irq_pin_oe_o}, 32'h6000);
      wr(IDX_WDOG, 8'h55);
      chk(resp, RESP_SLVERR);
      pwr(rec_exp(1'b0, 1'b1));
      rd(IDX_REC);
      chk(rdat, 32'h0);
      for (int k = 0; k < 4; k++) begin
         v = $random(seed);
         func_pin_low_i <= v[8];
         wr(IDX_WDOG, v[7:0]);
         rd(IDX_WDOG);
         chk(rdat, {24'h0, v[7:0]});
      end
      wr(IDX_WDOG, 8'h00);
      wr(IDX_CTRL, 8'h00);
      @(negedge clk_i) chk(shared_irq_pin_i, 0);
      wr(IDX_CTRL, 8'h80);
      @(negedge clk_i) chk(shared_irq_pin_i, 1);
      wr(IDX_CENTURY, 8'h80);
      roll();
      rd(IDX_CENTURY);
      chk(rdat, 32'hc0);
      wr(IDX_CENTURY, 8'h40);
      roll();
      rd(IDX_CENTURY);
      chk(rdat, 32'h40);
      wr(IDX_CTRL, 8'hc0);
      wr(IDX_REC, 8'h80);
      wr(IDX_IRQ_MASK, 8'h01);
      wr(IDX_ALARM, 8'he0);
      wr(IDX_FREEZE, 8'h00);
      bat_lvl <= 1'b0;
      pwr(rec_exp(1'b1, 1'b1));
      rd(IDX_FLAGS);
      bat_lvl <= 1'b1;
      chk(rdat, 32'h10);
      chk(irq_o, 1);
      rd(IDX_REC);
      chk(rdat, 32'h80);
      chk({frequency_test_o, update_freeze_o, alarm_irq_allow_o, backup_alarm_allow_o, square_wave_on_o}, 5'h08);
      wr(IDX_IRQ_MASK, 8'h00);
      chk(irq_o, 0);
      wr(IDX_IRQ_MASK, 8'h01);
      wr(IDX_IRQ_STAT, 8'h0f);
      chk(irq_o, 0);
      repeat (80) @(posedge clk_i);
      rd(IDX_FLAGS);
      chk(rdat, 32'h0);
      wr(IDX_REC, 8'h00);
      wr(IDX_HALT, 8'h00);
      pwr(rec_exp(1'b0, 1'b0));
      @(posedge clk_i) sense_lvl <= 1'b1;
      repeat (6) @(negedge clk_i);
      chk(supply_fail_out_o, 1);
      @(posedge clk_i) sense_lvl <= 1'b0;
      repeat (6) @(negedge clk_i);
      chk(supply_fail_out_o, 0);
      rd(IDX_IRQ_STAT);
      chk(rdat, 32'h0a);
      rd(6'h3f);
      chk(resp, RESP_DECERR);
      stop_test();
   end
   initial begin
      #400000;
      miscompares++;
      stop_test();
   end
endmodule
